// ### seq_consts.svh
// Purpose: constants for the burner start and purge sequencer
// Assumes: 40 MHz clock, register port with one-cycle read data
// Notes: offsets are word indices on the plain register port
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

`define ADDR_W 4
// register offsets
`define REG_CFG 4'h0
`define REG_ASSIGN 4'h1
`define REG_HOSTREQ 4'h2
`define REG_STATUS 4'h3
`define REG_CMD 4'h4
`define REG_PURGE_T 4'h5
`define REG_JUDGE_T 4'h6
// cfg fields
`define CFG_START_TYPE_LSB 0
`define CFG_START_METHOD_LSB 2
`define CFG_PURGE_USE_LSB 4
`define CFG_SYNC_SRC_LSB 6
`define CFG_COUNT_SRC_LSB 8
`define CFG_FURNACE_MODE_LSB 10
`define CFG_MASTER_BIT 12
// assign fields: fire position selects 0 = unmonitored, 1..16 = terminal
`define ASG_HIGH_LSB 0
`define ASG_LOW_LSB 5
`define ASG_FURN1_BIT 10
`define ASG_FURN2_BIT 11
`define ASG_SYNC_BIT 12
`define ASG_COUNT_BIT 13
`define ASG_ZONE_BIT 14
// host request bits
`define HQ_START_BIT 0
`define HQ_MAIN_BIT 1
`define HQ_SYNC_BIT 2
`define HQ_COUNT_BIT 3
// command bits
`define CMD_RESET_BIT 0
// default timing in ms, converted with the 40 MHz rate
`define CLK_KHZ 40000
`define PURGE_MS_DEF 16'h0064
`define JUDGE_MS_DEF 16'h0BB8
`define CYC_PER_MS 16'h9C40
// error codes shown in status
`define ERR_NONE 2'h0
`define ERR_FURNACE 2'h1
`define ERR_FIRE 2'h2
`define ERR_CONFIG 2'h3

`endif

// ### seq_pkg.sv
// Purpose: types for the burner start and purge sequencer
// Assumes: nothing beyond the constants header
// Notes: state codes are reported in the status register
package seq_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_MONITOR = 4'h1,
        ST_SYNC_WAIT = 4'h2,
        ST_COUNT_WAIT = 4'h3,
        ST_PREPURGE = 4'h4,
        ST_PILOT = 4'h5,
        ST_MAIN_WAIT = 4'h6,
        ST_MAIN = 4'h7,
        ST_POSTPURGE = 4'h8,
        ST_LOCKOUT = 4'h9,
        ST_PILOT_WAIT = 4'hA
    } state_e;

    typedef enum logic [1:0] {
        START_LINK1 = 2'h0,
        START_LINK2 = 2'h1,
        START_SEPARATE = 2'h2
    } start_type_e;

    typedef enum logic [1:0] {
        METH_SWITCH = 2'h0,
        METH_COMM = 2'h1,
        METH_AND = 2'h2,
        METH_OR = 2'h3
    } start_method_e;

    typedef enum logic [1:0] {
        PURGE_OFF = 2'h0,
        PURGE_ON = 2'h1,
        PURGE_BY_INPUT = 2'h2
    } purge_use_e;

    typedef enum logic [1:0] {
        SRC_INPUT = 2'h0,
        SRC_COMM = 2'h1,
        SRC_INTERNAL = 2'h2
    } src_e;
endpackage

// ### burner_start_purge_sequencer.sv
// Purpose: start, purge and ignition sequencer of a burner interlock module
// Assumes: field inputs are asynchronous; register port is on the clock
// Notes: one packed struct holds all state; outputs come from flip-flops
// How it works
// (R1) furnace mode needs both inputs assigned
// (R2) furnace inputs without mode: lockout, error
// (R3) first chained type runs whole sequence
// (R4) second chained type waits main start
// (R5) separate type waits pilot then main
// (R6) start by switch, host, and, or
// (R7) monitoring begins when start condition true
// (R8) purge off: no prepurge, no postpurge
// (R9) purge on: prepurge before, postpurge after
// (R10) zone purge input decides purging
// (R11) master unit cannot disable purging
// (R12) blower sync from input, host, internal
// (R13) unassigned sync input stalls blower wait
// (R14) purge count start from three sources
// (R15) unassigned count input stalls count wait
// (R16) fire positions unmonitored or terminal 1-16
// (R17) both positions on flags contradiction
// (R18) low fire position qualifies low stop
// (R19) contradiction held judgment time locks out
// (R20) lockout holds outputs until reset
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "seq_consts.svh"

module burner_start_purge_sequencer
    import seq_pkg::*;
(
    input wire logic clock, // 40 MHz clock
    input wire logic rst, // async reset, active high
    input wire logic [`ADDR_W-1:0] addr, // register index
    input wire logic [15:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [15:0] rdata, // read data, cycle after rd
    input wire logic start_sw, // startup switch input
    input wire logic pilot_start, // pilot start input
    input wire logic main_start, // main start input
    input wire logic sync_in, // blower sync input
    input wire logic count_in, // start purge count input
    input wire logic zone_purge, // zone purge on/off input
    input wire logic [15:0] interlock, // interlock terminals 1..16
    output logic blower, // blower output
    output logic pilot_valve, // pilot ignition output
    output logic main_valve, // main valve output
    output logic lockout, // lockout indication
    output logic furnace_mode, // furnace temperature mode active
    output logic fire_conflict, // both fire positions on
    output logic low_stop_ok // low fire position confirmed
);
    typedef struct packed {
        state_e st;
        logic [15:0] cfg;
        logic [15:0] asg;
        logic [3:0] hreq;
        logic [15:0] purge_ms;
        logic [15:0] judge_ms;
        logic [15:0] sub;
        logic [15:0] ms;
        logic [15:0] jsub;
        logic [15:0] jms;
        logic [1:0] err;
        logic [2:0] s_sw, s_pil, s_main, s_sync, s_cnt, s_zone;
        logic [15:0] lk1, lk2, lk3;
        logic [15:0] lkh;
        logic [5:0] held;
        logic [15:0] rdata;
        logic blower, pilot_valve, main_valve, lockout;
        logic furnace_mode, fire_conflict, low_stop_ok;
    } state_s;

    state_s r, n;

    logic [15:0] lk;
    logic sw, pil, mst, syn, cnt, zon;
    logic start_ok, purging, sync_ok, count_ok, hi_on, lo_on, both_asg;
    logic [4:0] hi_sel, lo_sel;
    start_type_e stype;
    start_method_e meth;
    purge_use_e puse;
    src_e ssrc, csrc;
    logic [1:0] fmode;

    // debounced view: a change counts when stages two and three agree
    always_comb begin
        // a disagreement keeps the last level, so a glitch is lost
        sw = r.held[0];
        pil = r.held[1];
        mst = r.held[2];
        syn = r.held[3];
        cnt = r.held[4];
        zon = r.held[5];
        lk = (~(r.lk2 ^ r.lk3) & r.lk3) | ((r.lk2 ^ r.lk3) & r.lkh);
        if (r.s_sw[1] == r.s_sw[2]) sw = r.s_sw[1];
        if (r.s_pil[1] == r.s_pil[2]) pil = r.s_pil[1];
        if (r.s_main[1] == r.s_main[2]) mst = r.s_main[1];
        if (r.s_sync[1] == r.s_sync[2]) syn = r.s_sync[1];
        if (r.s_cnt[1] == r.s_cnt[2]) cnt = r.s_cnt[1];
        if (r.s_zone[1] == r.s_zone[2]) zon = r.s_zone[1];
    end

    // configuration decode and sequencing conditions
    always_comb begin
        stype = start_type_e'(r.cfg[`CFG_START_TYPE_LSB +: 2]);
        meth = start_method_e'(r.cfg[`CFG_START_METHOD_LSB +: 2]);
        puse = purge_use_e'(r.cfg[`CFG_PURGE_USE_LSB +: 2]);
        ssrc = src_e'(r.cfg[`CFG_SYNC_SRC_LSB +: 2]);
        csrc = src_e'(r.cfg[`CFG_COUNT_SRC_LSB +: 2]);
        fmode = r.cfg[`CFG_FURNACE_MODE_LSB +: 2];
        hi_sel = r.asg[`ASG_HIGH_LSB +: 5];
        lo_sel = r.asg[`ASG_LOW_LSB +: 5];

        // (R6) start condition select
        unique case (meth)
            METH_SWITCH: start_ok = sw;
            METH_COMM: start_ok = r.hreq[`HQ_START_BIT];
            METH_AND: start_ok = sw & r.hreq[`HQ_START_BIT];
            METH_OR: start_ok = sw | r.hreq[`HQ_START_BIT];
        endcase

        // (R8) (R9) (R10) purge decision; (R11) master forces purging
        purging = 1'b1;
        if (!r.cfg[`CFG_MASTER_BIT]) begin
            if (puse == PURGE_OFF) purging = 1'b0;
            else if (puse == PURGE_BY_INPUT) purging = zon & r.asg[`ASG_ZONE_BIT];
        end

        // (R12) (R13) blower sync source
        sync_ok = 1'b0;
        if (ssrc == SRC_INPUT) sync_ok = syn & r.asg[`ASG_SYNC_BIT];
        else if (ssrc == SRC_COMM) sync_ok = r.hreq[`HQ_SYNC_BIT];
        else if (ssrc == SRC_INTERNAL) sync_ok = r.blower;

        // (R14) (R15) purge count start source
        count_ok = 1'b0;
        if (csrc == SRC_INPUT) count_ok = cnt & r.asg[`ASG_COUNT_BIT];
        else if (csrc == SRC_COMM) count_ok = r.hreq[`HQ_COUNT_BIT];
        else if (csrc == SRC_INTERNAL) count_ok = 1'b1;

        // (R16) fire position terminal mapping, 0 means unmonitored
        // selects above 16 count as unmonitored too
        hi_on = (hi_sel >= 5'h01) && (hi_sel <= 5'h10) && lk[4'(hi_sel - 5'h01)];
        lo_on = (lo_sel >= 5'h01) && (lo_sel <= 5'h10) && lk[4'(lo_sel - 5'h01)];
        both_asg = r.asg[`ASG_FURN1_BIT] & r.asg[`ASG_FURN2_BIT];
    end

    // next state of the whole block
    always_comb begin
        n = r;
        n.s_sw = {r.s_sw[1:0], start_sw};
        n.s_pil = {r.s_pil[1:0], pilot_start};
        n.s_main = {r.s_main[1:0], main_start};
        n.s_sync = {r.s_sync[1:0], sync_in};
        n.s_cnt = {r.s_cnt[1:0], count_in};
        n.s_zone = {r.s_zone[1:0], zone_purge};
        n.lk1 = interlock;
        n.lk2 = r.lk1;
        n.lk3 = r.lk2;
        n.lkh = lk;
        n.held = {zon, cnt, syn, mst, pil, sw};

        // register writes
        // status is read only; writes to gaps change nothing
        if (wr) begin
            unique case (addr)
                `REG_CFG: n.cfg = wdata;
                `REG_ASSIGN: n.asg = wdata;
                `REG_HOSTREQ: n.hreq = wdata[3:0];
                `REG_PURGE_T: n.purge_ms = wdata;
                `REG_JUDGE_T: n.judge_ms = wdata;
                default: ;
            endcase
        end

        // register reads, unmapped reads return zero
        n.rdata = 16'h0000;
        if (rd) begin
            unique case (addr)
                `REG_CFG: n.rdata = r.cfg;
                `REG_ASSIGN: n.rdata = r.asg;
                `REG_HOSTREQ: n.rdata = {12'h000, r.hreq};
                `REG_STATUS: n.rdata = {7'h00, r.low_stop_ok, r.fire_conflict,
                    r.furnace_mode, r.err, r.st};
                `REG_PURGE_T: n.rdata = r.purge_ms;
                `REG_JUDGE_T: n.rdata = r.judge_ms;
                default: n.rdata = 16'h0000;
            endcase
        end

        // (R1) furnace mode only with both inputs assigned
        n.furnace_mode = (fmode != 2'h0) && both_asg;

        // (R17) contradiction flag; (R18) low stop qualifier
        n.fire_conflict = (hi_sel != 5'h00) && (lo_sel != 5'h00) && hi_on && lo_on;
        n.low_stop_ok = lo_on;

        // (R19) judgment timer runs while the contradiction holds
        // any gap in the contradiction restarts the count
        if (r.fire_conflict) begin
            if (r.jsub == `CYC_PER_MS - 16'h0001) begin
                n.jsub = 16'h0000;
                n.jms = r.jms + 16'h0001;
            end else begin
                n.jsub = r.jsub + 16'h0001;
            end
        end else begin
            n.jsub = 16'h0000;
            n.jms = 16'h0000;
        end

        // sequence timer default: one ms tick counter
        if (r.sub == `CYC_PER_MS - 16'h0001) begin
            n.sub = 16'h0000;
            n.ms = r.ms + 16'h0001;
        end else begin
            n.sub = r.sub + 16'h0001;
        end

        // sequencer
        unique case (r.st)
            ST_IDLE: begin
                n.blower = 1'b0;
                n.pilot_valve = 1'b0;
                n.main_valve = 1'b0;
                // (R7) monitoring begins on start condition
                if (start_ok) n.st = ST_MONITOR;
            end

            ST_MONITOR: begin
                // (R5) separate type halts after monitoring
                if (!start_ok) n.st = ST_IDLE;
                else if (stype == START_SEPARATE) n.st = ST_PILOT_WAIT;
                else if (purging) begin
                    n.st = ST_SYNC_WAIT;
                    n.blower = 1'b1;
                end else n.st = ST_PILOT; // (R8) direct start
            end

            ST_PILOT_WAIT: begin
                if (!start_ok) n.st = ST_IDLE;
                else if (pil) begin
                    if (purging) begin
                        n.st = ST_SYNC_WAIT;
                        n.blower = 1'b1;
                    end else n.st = ST_PILOT;
                end
            end

            ST_SYNC_WAIT: begin
                // (R13) stuck here without an assigned sync input
                if (sync_ok) n.st = ST_COUNT_WAIT;
            end

            ST_COUNT_WAIT: begin
                // (R15) stuck here without an assigned count input
                if (count_ok) begin
                    n.st = ST_PREPURGE;
                    n.sub = 16'h0000;
                    n.ms = 16'h0000;
                end
            end

            ST_PREPURGE: begin
                // (R9) prepurge must finish before ignition
                if (r.ms >= r.purge_ms) begin
                    n.st = ST_PILOT;
                    n.blower = 1'b0;
                end
            end

            ST_PILOT: begin
                n.pilot_valve = 1'b1;
                // (R3) chained type goes straight on; (R4) others wait main
                if (stype == START_LINK1) n.st = ST_MAIN;
                else n.st = ST_MAIN_WAIT;
            end

            ST_MAIN_WAIT: begin
                if (mst || (stype == START_LINK2 && r.hreq[`HQ_MAIN_BIT]))
                    n.st = ST_MAIN;
            end

            ST_MAIN: begin
                n.main_valve = 1'b1;
            end

            ST_POSTPURGE: begin
                // postpurge reuses the prepurge time
                if (r.ms >= r.purge_ms) begin
                    n.st = ST_IDLE;
                    n.blower = 1'b0;
                end
            end

            ST_LOCKOUT: begin
                // reset refused while a cause stands, so a stuck
                // fault never drops straight back into a sequence
                // (R20) outputs off until reset with cause removed
                n.blower = 1'b0;
                n.pilot_valve = 1'b0;
                n.main_valve = 1'b0;
                n.lockout = 1'b1;
                if (wr && addr == `REG_CMD && wdata[`CMD_RESET_BIT]
                    && !(both_asg && fmode == 2'h0) && !r.fire_conflict) begin
                    n.st = ST_IDLE;
                    n.lockout = 1'b0;
                    n.err = `ERR_NONE;
                end
            end

            default: n.st = ST_LOCKOUT;
        endcase

        // start withdrawn before ignition: idle, blower off;
        // nothing has burned, so no postpurge is owed
        if ((r.st == ST_SYNC_WAIT || r.st == ST_COUNT_WAIT || r.st == ST_PREPURGE)
            && !start_ok) begin
            n.st = ST_IDLE;
            n.blower = 1'b0;
        end

        // burner stop once running: (R9) postpurge or (R8) none
        if ((r.st == ST_PILOT || r.st == ST_MAIN_WAIT || r.st == ST_MAIN)
            && !start_ok) begin
            n.pilot_valve = 1'b0;
            n.main_valve = 1'b0;
            if (purging) begin
                n.st = ST_POSTPURGE;
                n.blower = 1'b1;
                n.sub = 16'h0000;
                n.ms = 16'h0000;
            end else n.st = ST_IDLE;
        end

        // (R2) furnace inputs assigned while mode disabled
        if (r.st != ST_LOCKOUT && both_asg && fmode == 2'h0) begin
            n.st = ST_LOCKOUT;
            n.err = `ERR_FURNACE;
            n.blower = 1'b0;
            n.pilot_valve = 1'b0;
            n.main_valve = 1'b0;
        end

        // (R19) contradiction past judgment time locks out
        if (r.st != ST_LOCKOUT && r.fire_conflict && r.jms >= r.judge_ms) begin
            n.st = ST_LOCKOUT;
            n.err = `ERR_FIRE;
            n.blower = 1'b0;
            n.pilot_valve = 1'b0;
            n.main_valve = 1'b0;
        end
    end

    // one register stage holds all state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.purge_ms <= `PURGE_MS_DEF;
            r.judge_ms <= `JUDGE_MS_DEF;
            r.st <= ST_IDLE;
        end else begin
            r <= n;
        end
    end

    // outputs straight from flip-flops
    assign rdata = r.rdata;
    assign blower = r.blower;
    assign pilot_valve = r.pilot_valve;
    assign main_valve = r.main_valve;
    assign lockout = r.lockout;
    assign furnace_mode = r.furnace_mode;
    assign fire_conflict = r.fire_conflict;
    assign low_stop_ok = r.low_stop_ok;
endmodule

// ### seq_monitor.sv
// Purpose: port checker for the burner start and purge sequencer
// Assumes: configuration is only rewritten while the burner is idle
// Notes: config words are shadowed from register writes
`timescale 1ns/1ps
`include "seq_consts.svh"

module seq_monitor
    import seq_pkg::*;
(
    input wire logic clock, // clock
    input wire logic rst, // async reset
    input wire logic [`ADDR_W-1:0] addr, // register index
    input wire logic [15:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic blower, // blower out
    input wire logic pilot_valve, // pilot out
    input wire logic main_valve, // main out
    input wire logic lockout, // lockout out
    input wire logic furnace_mode, // furnace mode out
    input wire logic fire_conflict, // conflict out
    input wire logic low_stop_ok // low fire out
);
    logic [15:0] cfg;
    logic [15:0] asg;
    logic fm_on;
    logic fm_ok;
    logic both_asg;
    logic both_pos;
    logic low_asg;
    logic purge_on;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // decoded shadow fields
    assign fm_on = cfg[`CFG_FURNACE_MODE_LSB +: 2] != 2'h0;
    assign both_asg = asg[`ASG_FURN1_BIT] && asg[`ASG_FURN2_BIT];
    assign fm_ok = fm_on && both_asg;
    assign low_asg = asg[`ASG_LOW_LSB +: 5] != 5'h00;
    assign both_pos = low_asg && asg[`ASG_HIGH_LSB +: 5] != 5'h00;
    assign purge_on = cfg[`CFG_PURGE_USE_LSB +: 2] == 2'h1 || cfg[`CFG_MASTER_BIT];
    // shadows of the configuration words
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg <= 16'h0000;
            asg <= 16'h0000;
        end else begin
            if (wr && addr == `REG_CFG) begin
                cfg <= wdata;
            end
            if (wr && addr == `REG_ASSIGN) begin
                asg <= wdata;
            end
        end
    end
    property p_lock_off; lockout |-> !blower && !pilot_valve && !main_valve; endproperty
    a_lock_off: assert property (p_lock_off) else $error("output on in lockout");
    property p_lock_hold; lockout && !wr && !$past(wr) && !$past(wr, 2) |=> lockout; endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lockout left alone");
    property p_furn; furnace_mode |-> fm_ok || $past(fm_ok); endproperty
    a_furn: assert property (p_furn) else $error("furnace mode unqualified");
    property p_furn_err; (!fm_on && both_asg) [*8] |-> ##[0:40] lockout; endproperty
    a_furn_err: assert property (p_furn_err) else $error("no furnace lockout");
    property p_no_purge; cfg[5:4] == 2'h0 && !cfg[`CFG_MASTER_BIT] |-> !blower; endproperty
    a_no_purge: assert property (p_no_purge) else $error("blower with purge off");
    property p_prepurge; $rose(pilot_valve) && purge_on |-> $past(blower, 2); endproperty
    a_prepurge: assert property (p_prepurge) else $error("pilot without purge");
    property p_order; $rose(main_valve) |-> $past(pilot_valve); endproperty
    a_order: assert property (p_order) else $error("main before pilot");
    property p_conflict; fire_conflict |-> both_pos || $past(both_pos); endproperty
    a_conflict: assert property (p_conflict) else $error("conflict unassigned");
    property p_low; low_stop_ok |-> low_asg || $past(low_asg); endproperty
    a_low: assert property (p_low) else $error("low fire unassigned");
endmodule

// ### field_model.sv
// Purpose: burner field side, switches and fire position contacts
// Assumes: bench sets wanted levels just after a clock edge
// Notes: slow mode lags two cycles, like contacts that settle late
`timescale 1ns/1ps

module field_model (
    input wire logic clock, // clock
    input wire logic rst, // reset
    input wire logic slow, // add contact lag
    input wire logic [21:0] want, // wanted levels
    output logic [5:0] pins, // zone,count,sync,main,pilot,start
    output logic [15:0] interlock // terminals 1..16
);
    logic [21:0] d1;
    logic [21:0] d2;
    // lag line
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            d1 <= 22'h000000;
            d2 <= 22'h000000;
        end else begin
            d1 <= want;
            d2 <= d1;
        end
    end
    assign {pins, interlock} = slow ? d2 : want;
endmodule

// ### testbench.sv
// Purpose: self-checking bench for the burner start and purge sequencer
// Assumes: purge time 0 ms so sequences settle in a few dozen cycles
// Notes: fire judgment runs 1 ms, the longest part of the run
`timescale 1ns/1ps
`include "seq_consts.svh"

module testbench;
    import seq_pkg::*;
    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] asg;
        logic [3:0] hq;
        logic [5:0] pins;
        logic [3:0] st;
        logic bl;
        logic fm;
    } row_s;
    // cfg, assign, host, pins, settled state, blower seen, furnace mode
    localparam row_s ROWS [0:19] = '{
        '{16'h0290, 16'h0000, 4'h0, 6'h01, ST_MAIN, 1'b1, 1'b0},
        '{16'h0291, 16'h0000, 4'h0, 6'h01, ST_MAIN_WAIT, 1'b1, 1'b0},
        '{16'h0291, 16'h0000, 4'h2, 6'h01, ST_MAIN, 1'b1, 1'b0},
        '{16'h0291, 16'h0000, 4'h0, 6'h05, ST_MAIN, 1'b1, 1'b0},
        '{16'h0292, 16'h0000, 4'h0, 6'h01, ST_PILOT_WAIT, 1'b0, 1'b0},
        '{16'h0292, 16'h0000, 4'h0, 6'h03, ST_MAIN_WAIT, 1'b1, 1'b0},
        '{16'h0292, 16'h0000, 4'h0, 6'h07, ST_MAIN, 1'b1, 1'b0},
        '{16'h0280, 16'h0000, 4'h0, 6'h01, ST_MAIN, 1'b0, 1'b0},
        '{16'h1280, 16'h0000, 4'h0, 6'h01, ST_MAIN, 1'b1, 1'b0},
        '{16'h02A0, 16'h4000, 4'h0, 6'h01, ST_MAIN, 1'b0, 1'b0},
        '{16'h02A0, 16'h4000, 4'h0, 6'h21, ST_MAIN, 1'b1, 1'b0},
        '{16'h0210, 16'h0000, 4'h0, 6'h09, ST_SYNC_WAIT, 1'b1, 1'b0},
        '{16'h0250, 16'h0000, 4'h4, 6'h01, ST_MAIN, 1'b1, 1'b0},
        '{16'h0210, 16'h1000, 4'h0, 6'h09, ST_MAIN, 1'b1, 1'b0},
        '{16'h0090, 16'h0000, 4'h0, 6'h11, ST_COUNT_WAIT, 1'b1, 1'b0},
        '{16'h0190, 16'h0000, 4'h8, 6'h01, ST_MAIN, 1'b1, 1'b0},
        '{16'h0090, 16'h2000, 4'h0, 6'h11, ST_MAIN, 1'b1, 1'b0},
        '{16'h0690, 16'h0C00, 4'h0, 6'h01, ST_MAIN, 1'b1, 1'b1},
        '{16'h0690, 16'h0400, 4'h0, 6'h01, ST_MAIN, 1'b1, 1'b0},
        '{16'h0280, 16'h0C00, 4'h0, 6'h01, ST_LOCKOUT, 1'b0, 1'b0}};
    logic clock, rst, wr, rd, slow, bl_seen, sw, hq, exp_go;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, got;
    logic [21:0] want;
    logic [5:0] pins;
    logic [15:0] interlock;
    logic blower, pilot_valve, main_valve, lockout, furnace_mode, fire_conflict, low_stop_ok;
    int num_errors, n_checks, i, meth;

    burner_start_purge_sequencer dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .start_sw(pins[0]), .pilot_start(pins[1]),
        .main_start(pins[2]), .sync_in(pins[3]), .count_in(pins[4]), .zone_purge(pins[5]),
        .interlock(interlock), .blower(blower), .pilot_valve(pilot_valve),
        .main_valve(main_valve), .lockout(lockout), .furnace_mode(furnace_mode),
        .fire_conflict(fire_conflict), .low_stop_ok(low_stop_ok));
    field_model fields (.clock(clock), .rst(rst), .slow(slow), .want(want), .pins(pins),
        .interlock(interlock));

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, e, g);
        end
    endtask
    task automatic chk_bit(input string name, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %b, seen %b", name, e, g);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rreg(input logic [3:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(posedge clock);
        got = rdata;
    endtask
    task automatic summarize();
        $display("checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // a reset command is tried first while any cause still stands
    task automatic stop_run();
        if (lockout === 1'b1) begin
            wreg(`REG_CMD, 16'h0001);
            repeat (10) @(posedge clock);
            chk_bit("lockout kept", 1'b1, lockout);
        end
        want <= 22'h000000;
        wreg(`REG_HOSTREQ, 16'h0000);
        wreg(`REG_ASSIGN, 16'h0000);
        wreg(`REG_CMD, 16'h0001);
        repeat (60) @(posedge clock);
        rreg(`REG_STATUS);
        chk("idle state", 16'h0000, {12'h000, got[3:0]});
    endtask
    task automatic run_row(input row_s r);
        slow <= 1'($urandom_range(0, 1));
        wreg(`REG_CFG, r.cfg);
        wreg(`REG_ASSIGN, r.asg);
        wreg(`REG_HOSTREQ, {12'h000, r.hq});
        bl_seen = 1'b0;
        want <= {r.pins, 16'h0000};
        repeat (60) begin
            @(posedge clock);
            if (blower === 1'b1) bl_seen = 1'b1;
        end
        rreg(`REG_STATUS);
        chk("state", {12'h000, r.st}, {12'h000, got[3:0]});
        chk_bit("blower seen", r.bl, bl_seen);
        chk_bit("furnace mode", r.fm, furnace_mode);
        stop_run();
    endtask

    // clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // watchdog, well past the expected run length
    initial begin
        repeat (90000) @(posedge clock);
        num_errors++;
        summarize();
    end
    // main sequence
    initial begin
        {rst, wr, rd, slow, bl_seen} = 5'b10000;
        addr = 4'h0;
        wdata = 16'h0000;
        want = 22'h000000;
        num_errors = 0;
        n_checks = 0;
        void'($urandom(35047));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rreg(`REG_PURGE_T);
        chk("purge default", `PURGE_MS_DEF, got);
        rreg(`REG_JUDGE_T);
        chk("judge default", `JUDGE_MS_DEF, got);
        rreg(4'hF);
        chk("unmapped read", 16'h0000, got);
        wreg(`REG_PURGE_T, 16'h0000);
        foreach (ROWS[k]) run_row(ROWS[k]);
        // random start conditions on the separate type, which halts after monitoring
        for (i = 0; i < 12; i++) begin
            meth = $urandom_range(0, 3);
            sw = 1'($urandom_range(0, 1));
            hq = 1'($urandom_range(0, 1));
            exp_go = meth == 0 ? sw : meth == 1 ? hq : meth == 2 ? (sw & hq) : (sw | hq);
            run_row(row_s'{16'h0292 | 16'(meth << 2), 16'h0000, {3'h0, hq}, {5'h00, sw},
                exp_go ? ST_PILOT_WAIT : ST_IDLE, 1'b0, 1'b0});
        end
        // fire positions on terminals 3 (high) and 5 (low)
        wreg(`REG_JUDGE_T, 16'h0001);
        wreg(`REG_ASSIGN, 16'h00A3);
        want <= 22'h000010;
        repeat (20) @(posedge clock);
        chk_bit("conflict", 1'b0, fire_conflict);
        chk_bit("low fire", 1'b1, low_stop_ok);
        want <= 22'h000014;
        repeat (20) @(posedge clock);
        chk_bit("conflict", 1'b1, fire_conflict);
        repeat (30000) @(posedge clock);
        chk_bit("early lockout", 1'b0, lockout);
        for (i = 0; i < 12000 && lockout !== 1'b1; i++) @(posedge clock);
        chk_bit("judged lockout", 1'b1, lockout);
        stop_run();
        wreg(`REG_ASSIGN, 16'h0003);
        want <= 22'h000014;
        repeat (20) @(posedge clock);
        chk_bit("unmonitored conflict", 1'b0, fire_conflict);
        chk_bit("unmonitored low", 1'b0, low_stop_ok);
        summarize();
    end
endmodule

bind burner_start_purge_sequencer seq_monitor mon (.*);
